// ==== lvc_cfg.svh ====
`ifndef LVC_CFG_SVH
`define LVC_CFG_SVH

// field widths
`define LVC_PROG_W      6
`define LVC_COL_W       3
`define LVC_EXT_W       8
`define LVC_CODE_W      9
`define LVC_TRIM_W      5
`define LVC_SUM_W       10
`define LVC_MV_W        14

// look-up table shape
`define LVC_ROM_ROWS    18
`define LVC_ROM_COLS    8
`define LVC_ROM_LAST    6'h11

// reset values
`define LVC_PROG_RST    6'h00
`define LVC_COL_RST     3'h0
`define LVC_EXT_RST     8'h00
`define LVC_CODE_RST    9'h000
`define LVC_TRIM_RST    5'h00
`define LVC_SUM_RST     10'h000

// supply scale at the reference temperature, in mV and degrees C
`define LVC_OFFSET_MV   14'hbb8
`define LVC_STEP_MV     14'h01e
`define LVC_TREF_C      8'h28

// reference entry of the table
`define LVC_REF_PROG    6'h0f
`define LVC_REF_COL     3'h2
`define LVC_REF_CODE    9'h064

`endif

// ==== lvc_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module lvc_host
(
   // clock
   input  wire logic              core_clk,
   // host commands
   output var  lvc_pkg::lvc_mode_t command_set,
   output var  lvc_pkg::lvc_cmd_t  host_cmd
);
   import lvc_pkg::*;

   initial
   begin
      command_set = LVC_BASIC;
      host_cmd    = '0;
   end

   // strobes last one cycle, values stay so nothing is sampled mid-change
   task automatic send(input logic [5:0] p, input logic [2:0] c, input logic [7:0] e, input logic [2:0] we);
      @(negedge core_clk);
      host_cmd = '{we[2], p, we[1], c, we[0], e};
      @(negedge core_clk);
      host_cmd = '{1'b0, p, 1'b0, c, 1'b0, e};
   endtask

   task automatic set_mode(input lvc_mode_t m);
      @(negedge core_clk);
      command_set = m;
   endtask
endmodule
`default_nettype wire

// ==== lvc_pkg.sv ====
`default_nettype none
package lvc_pkg;
   `include "lvc_cfg.svh"

   typedef enum logic {LVC_BASIC, LVC_EXTENDED} lvc_mode_t;

   typedef struct packed {
      logic                   prog_we;
      logic [`LVC_PROG_W-1:0] voltage_program_value;
      logic                   col_we;
      logic [`LVC_COL_W-1:0]  voltage_column_select;
      logic                   ext_we;
      logic [`LVC_EXT_W-1:0]  ext_program_value;
   } lvc_cmd_t;

   typedef struct packed {
      logic [`LVC_TRIM_W-1:0] trim_pad_value;
      logic [`LVC_TRIM_W-1:0] module_trim_calibration;
      logic                   use_calibration;
   } lvc_trim_t;

   typedef struct packed {
      lvc_mode_t              mode;
      logic [`LVC_PROG_W-1:0] prog;
      logic [`LVC_COL_W-1:0]  col;
      logic [`LVC_EXT_W-1:0]  ext;
      logic [`LVC_TRIM_W-1:0] trim;
      logic [`LVC_CODE_W-1:0] code;
      logic [`LVC_SUM_W-1:0]  sum;
      logic [`LVC_MV_W-1:0]   level_mv;
   } lvc_state_t;
endpackage
`default_nettype wire

// ==== lvc_rom.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "lvc_cfg.svh"
module lvc_rom
(
   // table index
   input  wire logic [`LVC_PROG_W-1:0] voltage_program_value,
   input  wire logic [`LVC_COL_W-1:0]  voltage_column_select,
   // converted code
   output logic      [`LVC_CODE_W-1:0] rom_code
);
   import lvc_pkg::*;

   // top column saturates at 256, hence nine bits per entry
   localparam logic [`LVC_CODE_W-1:0] TBL [0:`LVC_ROM_COLS-1][0:`LVC_ROM_ROWS-1] = '{
      '{9'h00d, 9'h00e, 9'h00f, 9'h00f, 9'h010, 9'h011, 9'h012, 9'h013, 9'h013,
        9'h014, 9'h015, 9'h016, 9'h016, 9'h017, 9'h018, 9'h019, 9'h019, 9'h01a},
      '{9'h030, 9'h031, 9'h032, 9'h033, 9'h034, 9'h035, 9'h036, 9'h037, 9'h038,
        9'h039, 9'h03a, 9'h03b, 9'h03c, 9'h03d, 9'h03e, 9'h03f, 9'h040, 9'h041},
      '{9'h052, 9'h053, 9'h054, 9'h056, 9'h057, 9'h058, 9'h059, 9'h05a, 9'h05c,
        9'h05d, 9'h05e, 9'h05f, 9'h061, 9'h062, 9'h063, 9'h064, 9'h066, 9'h067},
      '{9'h074, 9'h076, 9'h077, 9'h079, 9'h07a, 9'h07b, 9'h07d, 9'h07e, 9'h080,
        9'h081, 9'h083, 9'h084, 9'h086, 9'h087, 9'h089, 9'h08a, 9'h08c, 9'h08d},
      '{9'h096, 9'h098, 9'h09a, 9'h09c, 9'h09d, 9'h09f, 9'h0a1, 9'h0a2, 9'h0a4,
        9'h0a6, 9'h0a7, 9'h0a9, 9'h0ab, 9'h0ad, 9'h0ae, 9'h0b0, 9'h0b2, 9'h0b3},
      '{9'h0b9, 9'h0bb, 9'h0bd, 9'h0bf, 9'h0c0, 9'h0c2, 9'h0c4, 9'h0c6, 9'h0c8,
        9'h0ca, 9'h0cc, 9'h0ce, 9'h0d0, 9'h0d2, 9'h0d4, 9'h0d6, 9'h0d8, 9'h0da},
      '{9'h0db, 9'h0dd, 9'h0df, 9'h0e2, 9'h0e4, 9'h0e6, 9'h0e8, 9'h0ea, 9'h0ec,
        9'h0ef, 9'h0f1, 9'h0f3, 9'h0f5, 9'h0f7, 9'h0f9, 9'h0fc, 9'h0fe, 9'h100},
      '{9'h0fd, 9'h100, 9'h100, 9'h100, 9'h100, 9'h100, 9'h100, 9'h100, 9'h100,
        9'h100, 9'h100, 9'h100, 9'h100, 9'h100, 9'h100, 9'h100, 9'h100, 9'h100}
   };

   logic [`LVC_PROG_W-1:0] row;

   // rows past the stored range hold the last stored entry
   always_comb
   begin
      row = voltage_program_value;
      if (row > `LVC_ROM_LAST)
      begin
         row = `LVC_ROM_LAST;
      end
      rom_code = TBL[voltage_column_select][row[4:0]];
   end
endmodule
`default_nettype wire

// ==== lvc_top.sv ====
// Functional notes
// - basic: program and column latched separately
// - extended: one 8-bit value used directly
// - basic: code from fixed table, column by row
// - entry program 15, column 010 gives 100
// - five-bit trim added to the code
// - level is 3 V plus sum times 0.03 V
// - trim from pads or calibration, never both
`timescale 1ns/10ps
`default_nettype none
`include "lvc_cfg.svh"
module lvc_top
(
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              sys_rst,
   // host commands
   input  wire lvc_pkg::lvc_mode_t command_set,
   input  wire lvc_pkg::lvc_cmd_t  host_cmd,
   // trim sources
   input  wire lvc_pkg::lvc_trim_t trim_src,
   // to the supply generator
   output logic [`LVC_CODE_W-1:0] operating_voltage_code,
   output logic [`LVC_SUM_W-1:0]  display_supply_code,
   output logic [`LVC_MV_W-1:0]   display_supply_level
);
   import lvc_pkg::*;

   lvc_state_t             st_r;
   lvc_state_t             st_nxt;
   logic [`LVC_CODE_W-1:0] rom_code;

   // millivolts at the reference temperature for a given summed code
   function automatic logic [`LVC_MV_W-1:0] level_of(input logic [`LVC_SUM_W-1:0] s);
      logic [`LVC_MV_W-1:0] prod;
      prod = `LVC_MV_W'(s) * `LVC_STEP_MV;
      return `LVC_OFFSET_MV + prod;
   endfunction

   // zero-extend both operands before adding so nothing wraps
   function automatic logic [`LVC_SUM_W-1:0] add_trim(input logic [`LVC_CODE_W-1:0] c,
                                                     input logic [`LVC_TRIM_W-1:0] t);
      return `LVC_SUM_W'(c) + `LVC_SUM_W'(t);
   endfunction

   lvc_rom u_rom
   (
      .voltage_program_value (st_r.prog),
      .voltage_column_select (st_r.col),
      .rom_code              (rom_code)
   );

   always_comb
   begin
      st_nxt      = st_r;
      st_nxt.mode = command_set;
      // each basic command touches only its own field
      if (host_cmd.prog_we)
      begin
         st_nxt.prog = host_cmd.voltage_program_value;
      end
      if (host_cmd.col_we)
      begin
         st_nxt.col = host_cmd.voltage_column_select;
      end
      if (host_cmd.ext_we)
      begin
         st_nxt.ext = host_cmd.ext_program_value;
      end
      // one source only; calibration overrides the pads
      if (trim_src.use_calibration)
      begin
         st_nxt.trim = trim_src.module_trim_calibration;
      end
      else
      begin
         st_nxt.trim = trim_src.trim_pad_value;
      end
      case (st_r.mode)
         LVC_BASIC:
         begin
            st_nxt.code = rom_code;
         end
         LVC_EXTENDED:
         begin
            st_nxt.code = `LVC_CODE_W'(st_r.ext);
         end
         default:
         begin
            st_nxt.code = rom_code;
         end
      endcase
      st_nxt.sum      = add_trim(st_r.code, st_r.trim);
      st_nxt.level_mv = level_of(st_r.sum);
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         st_r.mode     <= LVC_BASIC;
         st_r.prog     <= `LVC_PROG_RST;
         st_r.col      <= `LVC_COL_RST;
         st_r.ext      <= `LVC_EXT_RST;
         st_r.trim     <= `LVC_TRIM_RST;
         st_r.code     <= `LVC_CODE_RST;
         st_r.sum      <= `LVC_SUM_RST;
         st_r.level_mv <= `LVC_OFFSET_MV;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign operating_voltage_code = st_r.code;
   assign display_supply_code    = st_r.sum;
   assign display_supply_level   = st_r.level_mv;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   a_prog_latch: assert property (
      host_cmd.prog_we |=> st_r.prog == $past(host_cmd.voltage_program_value))
      else $error("program value not latched");

   a_col_independent: assert property (
      host_cmd.col_we && !host_cmd.prog_we |=> st_r.prog == $past(st_r.prog)
                                             && st_r.col == $past(host_cmd.voltage_column_select))
      else $error("column command disturbed program value");

   a_ext_direct: assert property (
      host_cmd.ext_we && command_set == LVC_EXTENDED ##1 command_set == LVC_EXTENDED && !host_cmd.ext_we
      |=> operating_voltage_code == `LVC_CODE_W'($past(host_cmd.ext_program_value, 2)))
      else $error("extended value not passed through");

   a_basic_lookup: assert property (
      st_r.mode == LVC_BASIC |=> operating_voltage_code == $past(rom_code))
      else $error("basic code not from table");

   a_ref_entry: assert property (
      st_r.mode == LVC_BASIC && st_r.prog == `LVC_REF_PROG && st_r.col == `LVC_REF_COL
      |=> operating_voltage_code == `LVC_REF_CODE)
      else $error("reference entry wrong");

   a_trim_add: assert property (
      ##1 1'b1 |-> display_supply_code == add_trim($past(st_r.code), $past(st_r.trim)))
      else $error("trim not added");

   a_level_scale: assert property (
      ##2 1'b1 |-> display_supply_level == `LVC_OFFSET_MV + `LVC_MV_W'($past(st_r.sum)) * `LVC_STEP_MV)
      else $error("supply level scale wrong");

   a_trim_source: assert property (
      trim_src.use_calibration |=> st_r.trim == $past(trim_src.module_trim_calibration))
      else $error("calibration trim not selected");

   a_trim_pads: assert property (
      !trim_src.use_calibration |=> st_r.trim == $past(trim_src.trim_pad_value))
      else $error("pad trim not selected");

   a_no_wrap: assert property (
      ##1 1'b1 |-> display_supply_code >= `LVC_SUM_W'($past(st_r.code)))
      else $error("sum wrapped");

   a_ext_no_table: assert property (
      st_r.mode == LVC_EXTENDED |=> operating_voltage_code == `LVC_CODE_W'($past(st_r.ext)))
      else $error("extended code went through the table");

endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import lvc_pkg::*;

   typedef struct packed {
      logic       m;
      logic [5:0] p;
      logic [2:0] c;
      logic [7:0] e;
      logic [4:0] pad;
      logic [4:0] cal;
      logic       uc;
      logic [8:0] code;
   } lvc_row_t;

   logic       core_clk;
   logic       sys_rst;
   lvc_mode_t  command_set;
   lvc_cmd_t   host_cmd;
   lvc_trim_t  trim_src;
   logic [8:0] op_code;
   logic [9:0] sup_code;
   logic [13:0] sup_level;
   int         fail_count;
   int         checks;
   // mode, program, column, ext, pads, calibration, use_cal, code
   lvc_row_t   rows [13] = '{
      '{1'b0, 6'h0f, 3'h2, 8'h00, 5'h00, 5'h00, 1'b0, 9'h064},
      '{1'b0, 6'h00, 3'h0, 8'h00, 5'h05, 5'h09, 1'b0, 9'h00d},
      '{1'b0, 6'h05, 3'h1, 8'h00, 5'h0a, 5'h03, 1'b1, 9'h035},
      '{1'b0, 6'h01, 3'h3, 8'h00, 5'h00, 5'h00, 1'b0, 9'h076},
      '{1'b0, 6'h02, 3'h4, 8'h00, 5'h00, 5'h00, 1'b0, 9'h09a},
      '{1'b0, 6'h04, 3'h5, 8'h00, 5'h00, 5'h00, 1'b0, 9'h0c0},
      '{1'b0, 6'h03, 3'h6, 8'h00, 5'h00, 5'h00, 1'b0, 9'h0e2},
      '{1'b0, 6'h11, 3'h6, 8'h00, 5'h1f, 5'h00, 1'b0, 9'h100},
      '{1'b0, 6'h01, 3'h7, 8'h00, 5'h01, 5'h1f, 1'b1, 9'h100},
      '{1'b0, 6'h00, 3'h7, 8'h00, 5'h00, 5'h00, 1'b0, 9'h0fd},
      '{1'b0, 6'h28, 3'h2, 8'h00, 5'h00, 5'h00, 1'b0, 9'h067},
      '{1'b1, 6'h0f, 3'h2, 8'hff, 5'h1f, 5'h00, 1'b0, 9'h0ff},
      '{1'b1, 6'h0f, 3'h2, 8'h00, 5'h00, 5'h00, 1'b0, 9'h000}};

   lvc_top lvc_top_inst (.core_clk(core_clk), .sys_rst(sys_rst), .command_set(command_set),
      .host_cmd(host_cmd), .trim_src(trim_src), .operating_voltage_code(op_code),
      .display_supply_code(sup_code), .display_supply_level(sup_level));

   lvc_host lvc_host_inst (.core_clk(core_clk), .command_set(command_set), .host_cmd(host_cmd));

   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   task automatic chk(input logic [8:0] code, input logic [4:0] trim);
      logic [9:0]  s;
      logic [13:0] l;
      s = {1'b0, code} + {5'h00, trim};
      l = 14'hbb8 + 14'h01e * {4'h0, s};
      checks++;
      if (op_code !== code || sup_code !== s || sup_level !== l)
      begin
         fail_count++;
         $display("wrong value at %0t: code %0d sum %0d level %0d", $time, op_code, sup_code, sup_level);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      fail_count = 0;
      checks     = 0;
      sys_rst    = 1'b1;
      trim_src   = '0;
      repeat (8) @(posedge core_clk);
      @(negedge core_clk);
      sys_rst = 1'b0;
      chk(9'h000, 5'h00);
      foreach (rows[i])
      begin
         @(negedge core_clk);
         trim_src = '{rows[i].pad, rows[i].cal, rows[i].uc};
         lvc_host_inst.set_mode(lvc_mode_t'(rows[i].m));
         lvc_host_inst.send(rows[i].p, rows[i].c, rows[i].e, 3'b111);
         repeat (6) @(negedge core_clk);
         chk(rows[i].code, rows[i].uc ? rows[i].cal : rows[i].pad);
      end
      // each strobe latches only its own field
      trim_src = '{5'h04, 5'h1b, 1'b0};
      lvc_host_inst.set_mode(LVC_BASIC);
      lvc_host_inst.send(6'h0f, 3'h2, 8'h00, 3'b110);
      lvc_host_inst.send(6'h00, 3'h5, 8'h00, 3'b100);
      repeat (6) @(negedge core_clk);
      chk(9'h052, 5'h04);
      lvc_host_inst.send(6'h09, 3'h3, 8'h00, 3'b010);
      repeat (6) @(negedge core_clk);
      chk(9'h074, 5'h04);
      // extended value bypasses the table, basic settings survive it
      lvc_host_inst.set_mode(LVC_EXTENDED);
      lvc_host_inst.send(6'h11, 3'h7, 8'h2a, 3'b001);
      repeat (6) @(negedge core_clk);
      chk(9'h02a, 5'h04);
      lvc_host_inst.set_mode(LVC_BASIC);
      repeat (6) @(negedge core_clk);
      chk(9'h074, 5'h04);
      // second reset in mid-run clears everything despite live trim pads
      sys_rst = 1'b1;
      repeat (3) @(negedge core_clk);
      chk(9'h000, 5'h00);
      sys_rst = 1'b0;
      // after release the cleared program and column pick entry 0 of column 0
      repeat (6) @(negedge core_clk);
      chk(9'h00d, 5'h04);
      end_sim();
   end

   initial
   begin
      repeat (2000) @(posedge core_clk);
      fail_count++;
      end_sim();
   end
endmodule
`default_nettype wire
